// ===== rtl/t16wm_pkg.sv
// Overview of operation
// - Counting and flags advance only on the timer clock enable; non-PWM buffer loads happen every cycle.
// - A nonzero output mode field hands that channel's pin to the waveform.
// - Non-PWM codes: off, toggle, clear, set on match.
// - Fast PWM: code 10 clears on match, sets at bottom; 11 inverse.
// - Fast PWM code 01 toggles A only in mode 15; B holds its level.
// - Fast PWM codes 10/11 with compare equal to TOP skip match, keep bottom action.
// - Dual slope: code 10 clears on up match, sets on down; 11 inverse.
// - Dual slope code 01 toggles A only in mode 9.
// - Force bits act only in non-PWM modes.
// - Force write is a one-cycle strobe acting as a match now.
// - Force never sets a match flag nor clears the counter.
// - Force bit positions always read zero.
// - Mode is four bits: low pair in control A, high pair in B.
// - Non-PWM: immediate compare update, overflow at MAX, TOP per mode.
// - Phase correct: TOP fixed or register, load at TOP, overflow at bottom.
// - Fast PWM: TOP fixed or register, load at bottom, overflow at TOP.
// - Phase-frequency: TOP capture or compare A, load and overflow at bottom.
// - Clock select zero gives no clock enable; counter stands still.
package t16wm_pkg;
    localparam int T16WM_DW = 8;
    localparam int T16WM_AW = 4;
    localparam int T16WM_CW = 16;
    localparam int T16WM_PW = 10;
    // Register offsets
    localparam logic [3:0] OFS_CTRL_A = 4'h0;
    localparam logic [3:0] OFS_CTRL_B = 4'h1;
    localparam logic [3:0] OFS_CMPA_LO = 4'h2;
    localparam logic [3:0] OFS_CMPA_HI = 4'h3;
    localparam logic [3:0] OFS_CMPB_LO = 4'h4;
    localparam logic [3:0] OFS_CMPB_HI = 4'h5;
    localparam logic [3:0] OFS_CAP_LO = 4'h6;
    localparam logic [3:0] OFS_CAP_HI = 4'h7;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_CNT_LO = 4'h9;
    localparam logic [3:0] OFS_CNT_HI = 4'ha;
    // Field positions
    localparam int COMA_HI = 7;
    localparam int COMA_LO = 6;
    localparam int COMB_HI = 5;
    localparam int COMB_LO = 4;
    localparam int FORCE_A = 3;
    localparam int FORCE_B = 2;
    localparam int WGML_HI = 1;
    localparam int WGML_LO = 0;
    localparam int WGMH_HI = 4;
    localparam int WGMH_LO = 3;
    localparam int CS_HI = 2;
    localparam int CS_LO = 0;
    localparam int ST_OVF = 0;
    localparam int ST_MA = 1;
    localparam int ST_MB = 2;
    localparam int COM_UP = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_A_MASK = 8'hf3;
    localparam logic [7:0] CTRL_B_MASK = 8'h1f;
    // Waveform modes
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_PC8 = 4'h1;
    localparam logic [3:0] MODE_PC9 = 4'h2;
    localparam logic [3:0] MODE_PC10 = 4'h3;
    localparam logic [3:0] MODE_CTC_CMP = 4'h4;
    localparam logic [3:0] MODE_FAST8 = 4'h5;
    localparam logic [3:0] MODE_FAST9 = 4'h6;
    localparam logic [3:0] MODE_FAST10 = 4'h7;
    localparam logic [3:0] MODE_PFC_CAP = 4'h8;
    localparam logic [3:0] MODE_PFC_CMP = 4'h9;
    localparam logic [3:0] MODE_PC_CAP = 4'ha;
    localparam logic [3:0] MODE_PC_CMP = 4'hb;
    localparam logic [3:0] MODE_CTC_CAP = 4'hc;
    localparam logic [3:0] MODE_FAST_CAP = 4'he;
    localparam logic [3:0] MODE_FAST_CMP = 4'hf;
    localparam logic [15:0] TOP_MAX = 16'hffff;
    localparam logic [15:0] TOP_8 = 16'h00ff;
    localparam logic [15:0] TOP_9 = 16'h01ff;
    localparam logic [15:0] TOP_10 = 16'h03ff;
    localparam logic [15:0] BOTTOM = 16'h0000;
    // Output mode codes
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    // Clock select codes and prescale masks
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [9:0] PRE_M8 = 10'h007;
    localparam logic [9:0] PRE_M64 = 10'h03f;
    localparam logic [9:0] PRE_M256 = 10'h0ff;
    localparam logic [9:0] PRE_M1024 = 10'h3ff;
    typedef enum logic [3:0] {
        CL_NONPWM = 4'b0001,
        CL_FAST = 4'b0010,
        CL_PC = 4'b0100,
        CL_PFC = 4'b1000
    } t16wm_class_type;
endpackage : t16wm_pkg

// ===== rtl/t16wm_ctrl.sv
`timescale 1ns/1ps
module t16wm_ctrl (
    input wire logic ref_clk, // 40 MHz clock
    input wire logic reset, // Sync reset, high
    input wire logic [t16wm_pkg::T16WM_AW-1:0] addr, // Register index
    input wire logic [t16wm_pkg::T16WM_DW-1:0] wdata, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    output logic [t16wm_pkg::T16WM_DW-1:0] rdata, // Read data
    input wire logic t1_pin, // External count pin
    output logic wave_out_a, // Waveform A level
    output logic wave_out_b, // Waveform B level
    output logic wave_override_a, // A owns its pin
    output logic wave_override_b // B owns its pin
);
    import t16wm_pkg::*;

    // ==========================================================
    // Declarations
    logic [7:0] ctrl_a_ff;
    logic [7:0] ctrl_b_ff;
    logic [15:0] cmpa_buf_ff;
    logic [15:0] cmpb_buf_ff;
    logic [15:0] cmpa_ff;
    logic [15:0] cmpb_ff;
    logic [15:0] cap_ff;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic up_ff;
    logic nxt_up;
    logic [2:0] status_ff;
    logic [9:0] pre_ff;
    logic t1_meta_ff;
    logic t1_sync_ff;
    logic t1_prev_ff;
    logic wave_a_ff;
    logic wave_b_ff;
    logic ovr_a_ff;
    logic ovr_b_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [3:0] wmode;
    logic [3:0] wmode_wr;
    t16wm_class_type mclass;
    t16wm_class_type wr_class;
    logic [15:0] top;
    logic [2:0] csel;
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic tick;
    logic ev_top;
    logic ev_bottom;
    logic match_a;
    logic match_b;
    logic force_a;
    logic force_b;
    logic ovf_ev;
    logic load_buf;
    logic tog_fast;
    logic tog_dual;

    // ==========================================================
    // Mode decode functions
    function automatic t16wm_class_type class_of(input logic [3:0] m);
        t16wm_class_type c;
        c = CL_NONPWM;
        case (m)
            MODE_PC8, MODE_PC9, MODE_PC10,
            MODE_PC_CAP, MODE_PC_CMP: c = CL_PC;
            MODE_FAST8, MODE_FAST9, MODE_FAST10,
            MODE_FAST_CAP, MODE_FAST_CMP: c = CL_FAST;
            MODE_PFC_CAP, MODE_PFC_CMP: c = CL_PFC;
            default: c = CL_NONPWM; // Normal, clear-on-match, 13
        endcase
        return c;
    endfunction : class_of

    function automatic logic [15:0] top_of(input logic [3:0] m,
        input logic [15:0] cap, input logic [15:0] cmp);
        logic [15:0] t;
        t = TOP_MAX;
        case (m)
            MODE_PC8, MODE_FAST8: t = TOP_8;
            MODE_PC9, MODE_FAST9: t = TOP_9;
            MODE_PC10, MODE_FAST10: t = TOP_10;
            MODE_CTC_CMP, MODE_PFC_CMP,
            MODE_PC_CMP, MODE_FAST_CMP: t = cmp;
            MODE_CTC_CAP, MODE_PFC_CAP,
            MODE_PC_CAP, MODE_FAST_CAP: t = cap;
            default: t = TOP_MAX;
        endcase
        return t;
    endfunction : top_of

    // Next waveform level for one channel
    function automatic logic wave_next(input t16wm_class_type cl,
        input logic [1:0] com, input logic tf, input logic td,
        input logic match, input logic bot, input logic up,
        input logic at_top, input logic cur);
        logic v;
        v = cur;
        case (cl)
            CL_NONPWM: begin
                if (match) begin
                    case (com)
                        COM_TOGGLE: v = ~cur;
                        COM_CLEAR: v = 1'b0;
                        COM_SET: v = 1'b1;
                        default: v = cur;
                    endcase
                end
            end
            CL_FAST: begin
                if (com[COM_UP]) begin
                    if (bot) v = ~com[0];
                    if (match && !at_top) v = com[0];
                end else if (com == COM_TOGGLE && tf && match) begin
                    v = ~cur;
                end
            end
            CL_PC, CL_PFC: begin
                if (com[COM_UP] && match) begin
                    v = up ? com[0] : ~com[0];
                end else if (com == COM_TOGGLE && td && match) begin
                    v = ~cur;
                end
            end
            default: v = cur;
        endcase
        return v;
    endfunction : wave_next

    // ==========================================================
    // Decode of control state
    assign wmode = {ctrl_b_ff[WGMH_HI:WGMH_LO],
                    ctrl_a_ff[WGML_HI:WGML_LO]};
    assign mclass = class_of(wmode);
    // Mode as it stands once a control A write lands
    assign wmode_wr = {ctrl_b_ff[WGMH_HI:WGMH_LO],
                       wdata[WGML_HI:WGML_LO]};
    assign wr_class = class_of(wmode_wr);
    assign top = top_of(wmode, cap_ff, cmpa_ff);
    assign csel = ctrl_b_ff[CS_HI:CS_LO];
    assign com_a = ctrl_a_ff[COMA_HI:COMA_LO];
    assign com_b = ctrl_a_ff[COMB_HI:COMB_LO];
    assign tog_fast = (wmode == MODE_FAST_CMP);
    assign tog_dual = (wmode == MODE_PFC_CMP) ||
                      (wmode == MODE_FAST_CAP);

    // ==========================================================
    // Timer clock enable
    always_comb begin
        case (csel)
            CS_STOP: tick = 1'b0;
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = (pre_ff & PRE_M8) == PRE_M8;
            CS_DIV64: tick = (pre_ff & PRE_M64) == PRE_M64;
            CS_DIV256: tick = (pre_ff & PRE_M256) == PRE_M256;
            CS_DIV1024: tick = (pre_ff & PRE_M1024) == PRE_M1024;
            CS_EXT_FALL: tick = t1_prev_ff && !t1_sync_ff;
            CS_EXT_RISE: tick = !t1_prev_ff && t1_sync_ff;
            default: tick = 1'b0;
        endcase
    end

    // Free-running prescaler
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + 10'h001;
        end
    end

    // External pin synchroniser
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            t1_meta_ff <= 1'b0;
            t1_sync_ff <= 1'b0;
            t1_prev_ff <= 1'b0;
        end else begin
            t1_meta_ff <= t1_pin;
            t1_sync_ff <= t1_meta_ff;
            t1_prev_ff <= t1_sync_ff;
        end
    end

    // ==========================================================
    // Counter events
    assign ev_top = tick && (cnt_ff == top);
    assign ev_bottom = tick && (cnt_ff == BOTTOM);
    assign match_a = tick && (cnt_ff == cmpa_ff);
    assign match_b = tick && (cnt_ff == cmpb_ff);
    assign force_a = wr_en && addr == OFS_CTRL_A && wdata[FORCE_A] &&
                     wr_class == CL_NONPWM;
    assign force_b = wr_en && addr == OFS_CTRL_A && wdata[FORCE_B] &&
                     wr_class == CL_NONPWM;

    // Overflow and buffer load moments per class
    always_comb begin
        case (mclass)
            CL_NONPWM: begin
                ovf_ev = tick && (cnt_ff == TOP_MAX);
                load_buf = 1'b1;
            end
            CL_FAST: begin
                ovf_ev = ev_top;
                load_buf = ev_bottom;
            end
            CL_PC: begin
                ovf_ev = ev_bottom;
                load_buf = ev_top;
            end
            CL_PFC: begin
                ovf_ev = ev_bottom;
                load_buf = ev_bottom;
            end
            default: begin
                ovf_ev = 1'b0;
                load_buf = 1'b0;
            end
        endcase
    end

    // Count sequence, single or dual slope
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_up = up_ff;
        if (tick) begin
            case (mclass)
                CL_PC, CL_PFC: begin
                    if (up_ff && cnt_ff == top) begin
                        nxt_up = 1'b0;
                        nxt_cnt = cnt_ff - 16'h0001;
                    end else if (!up_ff && cnt_ff == BOTTOM) begin
                        nxt_up = 1'b1;
                        nxt_cnt = cnt_ff + 16'h0001;
                    end else begin
                        nxt_cnt = up_ff ? cnt_ff + 16'h0001
                                        : cnt_ff - 16'h0001;
                    end
                end
                default: begin
                    nxt_up = 1'b1;
                    nxt_cnt = (cnt_ff == top) ? BOTTOM
                                              : cnt_ff + 16'h0001;
                end
            endcase
        end
    end

    // Counter and direction, force never clears it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_ff <= BOTTOM;
            up_ff <= 1'b1;
        end else begin
            cnt_ff <= nxt_cnt;
            up_ff <= nxt_up;
        end
    end

    // ==========================================================
    // Control registers, force bits never stored
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_a_ff <= CTRL_RESET;
            ctrl_b_ff <= CTRL_RESET;
        end else if (wr_en) begin
            if (addr == OFS_CTRL_A) ctrl_a_ff <= wdata & CTRL_A_MASK;
            if (addr == OFS_CTRL_B) ctrl_b_ff <= wdata & CTRL_B_MASK;
        end
    end

    // Compare buffers and TOP capture register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cmpa_buf_ff <= '0;
            cmpb_buf_ff <= '0;
            cap_ff <= '0;
        end else if (wr_en) begin
            case (addr)
                OFS_CMPA_LO: cmpa_buf_ff[7:0] <= wdata;
                OFS_CMPA_HI: cmpa_buf_ff[15:8] <= wdata;
                OFS_CMPB_LO: cmpb_buf_ff[7:0] <= wdata;
                OFS_CMPB_HI: cmpb_buf_ff[15:8] <= wdata;
                OFS_CAP_LO: cap_ff[7:0] <= wdata;
                OFS_CAP_HI: cap_ff[15:8] <= wdata;
                default: cap_ff <= cap_ff;
            endcase
        end
    end

    // Active compare values
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cmpa_ff <= '0;
            cmpb_ff <= '0;
        end else if (load_buf) begin
            cmpa_ff <= cmpa_buf_ff;
            cmpb_ff <= cmpb_buf_ff;
        end
    end

    // Sticky flags, write one clears, set wins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            status_ff <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_en && addr == OFS_STATUS && wdata[i])
                    status_ff[i] <= 1'b0;
            end
            if (ovf_ev) status_ff[ST_OVF] <= 1'b1;
            if (match_a) status_ff[ST_MA] <= 1'b1;
            if (match_b) status_ff[ST_MB] <= 1'b1;
        end
    end

    // ==========================================================
    // Waveform generators and pin override
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wave_a_ff <= 1'b0;
            wave_b_ff <= 1'b0;
            ovr_a_ff <= 1'b0;
            ovr_b_ff <= 1'b0;
        end else begin
            wave_a_ff <= wave_next(force_a ? CL_NONPWM : mclass,
                force_a ? wdata[COMA_HI:COMA_LO] : com_a, tog_fast,
                tog_dual, match_a || force_a, ev_bottom, up_ff,
                cmpa_ff == top, wave_a_ff);
            wave_b_ff <= wave_next(force_b ? CL_NONPWM : mclass,
                force_b ? wdata[COMB_HI:COMB_LO] : com_b, 1'b0, 1'b0,
                match_b || force_b, ev_bottom, up_ff,
                cmpb_ff == top, wave_b_ff);
            ovr_a_ff <= |com_a;
            ovr_b_ff <= |com_b;
        end
    end

    // ==========================================================
    // Read port, data valid one cycle after strobe
    always_comb begin
        nxt_rdata = '0;
        if (rd_en) begin
            case (addr)
                OFS_CTRL_A: nxt_rdata = ctrl_a_ff & CTRL_A_MASK;
                OFS_CTRL_B: nxt_rdata = ctrl_b_ff;
                OFS_CMPA_LO: nxt_rdata = cmpa_buf_ff[7:0];
                OFS_CMPA_HI: nxt_rdata = cmpa_buf_ff[15:8];
                OFS_CMPB_LO: nxt_rdata = cmpb_buf_ff[7:0];
                OFS_CMPB_HI: nxt_rdata = cmpb_buf_ff[15:8];
                OFS_CAP_LO: nxt_rdata = cap_ff[7:0];
                OFS_CAP_HI: nxt_rdata = cap_ff[15:8];
                OFS_STATUS: nxt_rdata = {5'h00, status_ff};
                OFS_CNT_LO: nxt_rdata = cnt_ff[7:0];
                OFS_CNT_HI: nxt_rdata = cnt_ff[15:8];
                default: nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata = rdata_ff;
    assign wave_out_a = wave_a_ff;
    assign wave_out_b = wave_b_ff;
    assign wave_override_a = ovr_a_ff;
    assign wave_override_b = ovr_b_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_ctrl_read;
        rd_en && addr == OFS_CTRL_A;
    endsequence
    sequence s_fast_bottom;
        mclass == CL_FAST && com_a == COM_CLEAR && ev_bottom &&
        !match_a && !force_a;
    endsequence

    a_force_reads_zero: assert property (
        s_ctrl_read |=> rdata[FORCE_A] == 1'b0 &&
        rdata[FORCE_B] == 1'b0)
        else $error("force bits read nonzero");
    a_stop_no_count: assert property (
        csel == CS_STOP |=> $stable(cnt_ff))
        else $error("counter moved while stopped");
    a_count_on_tick: assert property (
        !tick |=> cnt_ff == $past(cnt_ff))
        else $error("counter moved without tick");
    a_pin_override: assert property (
        com_a != COM_OFF |=> wave_override_a)
        else $error("override A missing");
    a_force_no_flag: assert property (
        force_a && !match_a && !tick |=>
        $stable(status_ff[ST_MA]) && $stable(cnt_ff))
        else $error("force touched flag or counter");
    a_force_pwm_idle: assert property (
        wr_en && addr == OFS_CTRL_A && wdata[FORCE_A] &&
        wr_class != CL_NONPWM && !tick |=> $stable(wave_out_a))
        else $error("force acted in PWM mode");
    a_nonpwm_set: assert property (
        mclass == CL_NONPWM && com_a == COM_SET && match_a && !force_a |=>
        wave_out_a)
        else $error("set on match failed");
    a_fast_bottom_set: assert property (
        s_fast_bottom |=> wave_out_a)
        else $error("bottom set failed");
    a_dual_up_clear: assert property (
        mclass == CL_PC && com_a == COM_CLEAR && up_ff && match_a
        && !force_a |=> !wave_out_a)
        else $error("up match clear failed");
    a_ovf_flag_set: assert property (
        ovf_ev |=> status_ff[ST_OVF])
        else $error("overflow flag not set");
endmodule : t16wm_ctrl

// ===== verification/t16wm_pin_model.sv
`timescale 1ns/1ps
// ======================================
// Port pin model beside the waveform outputs
module t16wm_pin_model (
    input wire logic wave_a, // Waveform A level
    input wire logic wave_b, // Waveform B level
    input wire logic ovr_a, // A owns its pin
    input wire logic ovr_b, // B owns its pin
    input wire logic dir_a, // Direction bit, A pin
    input wire logic dir_b, // Direction bit, B pin
    input wire logic port_a, // Port value, A pin
    input wire logic port_b, // Port value, B pin
    output logic pin_a, // Level seen on A pin
    output logic pin_b // Level seen on B pin
);
    // Driver off without direction bit; pull-up holds the pin high
    assign pin_a = dir_a ? (ovr_a ? wave_a : port_a) : 1'b1;
    assign pin_b = dir_b ? (ovr_b ? wave_b : port_b) : 1'b1;
endmodule : t16wm_pin_model

// ===== verification/timer16_waveform_mode_control_tb.sv
`timescale 1ns/1ps
// ======================================
// Bench for the waveform mode control
module timer16_waveform_mode_control_tb;
    import t16wm_pkg::*;
    logic ref_clk;
    logic reset;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [7:0] rdata;
    logic t1_pin;
    logic wave_a, wave_b, ovr_a, ovr_b, pin_a, pin_b;
    logic [7:0] got;
    logic [7:0] cnt0;
    int fail_count;
    int n_tests;

    t16wm_ctrl u_dut (.ref_clk(ref_clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .t1_pin(t1_pin), .wave_out_a(wave_a), .wave_out_b(wave_b),
        .wave_override_a(ovr_a), .wave_override_b(ovr_b));
    t16wm_pin_model u_pins (.wave_a(wave_a), .wave_b(wave_b), .ovr_a(ovr_a),
        .ovr_b(ovr_b), .dir_a(1'b1), .dir_b(1'b0), .port_a(1'b0),
        .port_b(1'b0), .pin_a(pin_a), .pin_b(pin_b));

    // Clock generator
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Verdict and end of run
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task automatic check8(input logic [7:0] act, input logic [7:0] exp);
        n_tests++;
        if (act !== exp) begin
            fail_count++;
            $display("BAD t=%0t got %h exp %h", $time, act, exp);
        end
    endtask : check8

    // One-cycle write strobe, then two idle cycles so outputs settle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask : wr

    // One-cycle read strobe; data taken in the following cycle
    task automatic rd(input logic [3:0] a);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        got = rdata;
        @(posedge ref_clk);
    endtask : rd

    // Cycles until waveform A reaches a level, bounded
    task automatic wait_lvl(input logic v, output int n);
        n = 0;
        while (wave_a !== v && n < 3000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= 3000) check8({7'h0, wave_a}, {7'h0, v});
    endtask : wait_lvl

    // Configure a mode and measure the low phase of waveform A
    task automatic run_case(input logic [3:0] m, input logic [1:0] c,
            input logic [7:0] cmp, input int exp_low);
        logic [1:0] cb;
        int n;
        cb = c[1] ? (c ^ 2'h1) : 2'h0;
        wr(OFS_CMPA_LO, cmp);
        wr(OFS_CMPB_LO, cmp);
        wr(OFS_CTRL_B, {3'b000, m[3:2], CS_DIV1});
        wr(OFS_CTRL_A, {c, cb, 2'b00, m[1:0]});
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        check8(8'(n >= exp_low - 2 && n <= exp_low + 2), 8'h01);
        if (c[1]) check8({7'h0, wave_b}, {7'h0, ~wave_a});
    endtask : run_case

    // Watchdog
    initial begin
        repeat (60000) @(posedge ref_clk);
        fail_count++;
        complete_run();
    end

    // Main sequence
    initial begin
        int n;
        fail_count = 0;
        n_tests = 0;
        reset = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        t1_pin = 1'b0;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        // Reset value, access kinds, unmapped place
        rd(OFS_CTRL_A);
        check8(got, CTRL_RESET);
        wr(OFS_CTRL_A, 8'hf3);
        rd(OFS_CTRL_A);
        check8(got, 8'hf3);
        wr(4'hf, 8'hff);
        rd(4'hf);
        check8(got, 8'h00);
        // Normal mode: set A on match at count 2
        wr(OFS_CMPA_LO, 8'h02);
        wr(OFS_CTRL_A, 8'hc0);
        check8({6'h0, ovr_a, ovr_b}, 8'h02);
        check8({7'h0, pin_b}, 8'h01);
        wr(OFS_CTRL_B, {5'h00, CS_DIV1});
        wait_lvl(1'b1, n);
        check8(8'(n < 12), 8'h01);
        check8({7'h0, pin_a}, 8'h01);
        wr(OFS_CTRL_B, 8'h00);
        rd(OFS_STATUS);
        check8(got & 8'h02, 8'h02);
        // Stopped clock holds the counter
        rd(OFS_CNT_LO);
        cnt0 = got;
        repeat (20) @(posedge ref_clk);
        rd(OFS_CNT_LO);
        check8(got, cnt0);
        // Forced matches in clear-on-match mode
        wr(OFS_STATUS, 8'h07);
        wr(OFS_CTRL_B, 8'h08);
        wr(OFS_CTRL_A, 8'h88);
        check8({7'h0, wave_a}, 8'h00);
        wr(OFS_CTRL_A, 8'h48);
        check8({7'h0, wave_a}, 8'h01);
        wr(OFS_CTRL_A, 8'h48);
        check8({7'h0, wave_a}, 8'h00);
        wr(OFS_CTRL_A, 8'h3c);
        check8({6'h0, wave_a, wave_b}, 8'h01);
        rd(OFS_CTRL_A);
        check8(got, 8'h30);
        rd(OFS_STATUS);
        check8(got, 8'h00);
        rd(OFS_CNT_LO);
        check8(got, cnt0);
        // Force ignored once a PWM mode is selected
        wr(OFS_CTRL_A, 8'hc9);
        check8({7'h0, wave_a}, 8'h00);
        // Mode table: low-phase length of waveform A
        run_case(4'h4, 2'h1, 8'h20, 33);
        run_case(4'hf, 2'h1, 8'h20, 33);
        run_case(4'h9, 2'h1, 8'h20, 64);
        run_case(4'h5, 2'h2, 8'h10, 240);
        run_case(4'h5, 2'h3, 8'h10, 16);
        run_case(4'h1, 2'h2, 8'hf0, 30);
        run_case(4'h1, 2'h3, 8'hf0, 480);
        rd(OFS_STATUS);
        check8(got & 8'h01, 8'h01);
        complete_run();
    end
endmodule : timer16_waveform_mode_control_tb
